// ---- hw/ppcw_pkg.sv ----
/*
 Constants shared by the plot pixel cache writer: register map, option bits,
 layout encodings, RAM placement and state types.
 Assumes a byte-addressed bus with one 32-bit word per register.
*/
package ppcw_pkg;
    // ----------------------------------------
    // Register word indices (byte address = index * 4)
    // ----------------------------------------
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_COLOR  = 4'h1;
    localparam logic [3:0] REG_X      = 4'h2;
    localparam logic [3:0] REG_Y      = 4'h3;
    localparam logic [3:0] REG_SRC    = 4'h4;
    localparam logic [3:0] REG_POR    = 4'h5;
    localparam logic [3:0] REG_BASE   = 4'h6;
    localparam logic [3:0] REG_LAYOUT = 4'h7;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_AREA   = 4'h9;
    // ----------------------------------------
    // Commands written to the command register
    // ----------------------------------------
    localparam logic [2:0] OP_PLOT  = 3'h1;
    localparam logic [2:0] OP_COLOR = 3'h2;
    localparam logic [2:0] OP_ROMC  = 3'h3;
    localparam logic [2:0] OP_PIXEL_READBACK_FLUSH  = 3'h4;
    localparam logic [2:0] OP_MODE  = 3'h5;
    // ----------------------------------------
    // Plot option bits and layout fields
    // ----------------------------------------
    localparam int POR_TRANSP = 0;
    localparam int POR_DITHER = 1;
    localparam int POR_HINIB  = 2;
    localparam int POR_FREEZE = 3;
    localparam int POR_OBJ    = 4;
    localparam logic [1:0] CM_2BPP = 2'h0;
    localparam logic [1:0] CM_8BPP = 2'h3;
    localparam logic [1:0] HT_128  = 2'h0;
    localparam logic [1:0] HT_160  = 2'h1;
    localparam logic [1:0] HT_192  = 2'h2;
    localparam logic [1:0] HT_OBJ  = 2'h3;
    localparam logic [9:0] CHARS_128 = 10'h010;
    localparam logic [9:0] CHARS_160 = 10'h014;
    localparam logic [9:0] CHARS_192 = 10'h018;
    localparam logic [9:0] CHARS_OBJ = 10'h020;
    // ----------------------------------------
    // RAM placement
    // ----------------------------------------
    localparam logic [23:0] RAM_BANK_BASE = 24'h700000;
    localparam logic [7:0]  ROW_FULL      = 8'hff;
    typedef enum logic [1:0] {W_IDLE, W_READ, W_WRITE} ppcw_wst_t;
    typedef enum logic [1:0] {R_IDLE, R_FLUSH, R_READ} ppcw_rbst_t;
endpackage : ppcw_pkg

// ---- hw/ppcw_plot_writer.sv ----
/*
 Plot pixel cache writer: primary and secondary one-row pixel caches,
 planar conversion, read-merge-write and read-back to external RAM.
 Assumes an Avalon-MM master, and a RAM that pulses ram_ack once per access.
*/
// Summary of operation
// - Area base is bank 70 plus base*400h
// - Area size from height, width, bits per pixel
// - Color load from source or ROM byte
// - Plot uses X, Y registers and color
// - Pixels converted to planar data before storing
// - Cache holds eight 8-bit pixels, one row
// - Primary and secondary caches with pending masks
// - Row key from X[7:3], Y[7:0] compared
// - Same row: store pixel, flush when full
// - Flush moves primary, stalls while secondary busy
// - After full flush, clear primary, write concurrently
// - New row: flush primary, then store pixel
// - Incomplete row read back, merged, then written
// - Each plot increments X by one
// - Read-back flushes caches, then reads pixel
// - Read-back always reads RAM, no hit check
// - Mode-set loads plot option register
// - Transparent zero color only advances X
// - Dither picks nibble from X xor Y
`timescale 1ns/1ps
module ppcw_plot_writer #(
    parameter int SCREEN_WIDTH = 256
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Pipeline side
    input  wire logic [7:0]  rom_byte,
    // External RAM
    output logic             ram_req,
    output logic             ram_we,
    output logic      [23:0] ram_addr,
    output logic      [7:0]  ram_wdata,
    input  wire logic        ram_ack,
    input  wire logic [7:0]  ram_rdata
);
    if (SCREEN_WIDTH < 8 || SCREEN_WIDTH > 256 || SCREEN_WIDTH % 8 != 0)
    begin : g_bad_width
        $error("SCREEN_WIDTH must be a multiple of 8 up to 256");
    end

    logic [7:0]  color;
    logic [7:0]  x;
    logic [7:0]  y;
    logic [7:0]  src;
    logic [7:0]  base;
    logic [4:0]  por;
    logic [3:0]  layout;
    logic [7:0]  prim_pix [8];
    logic [7:0]  prim_mask;
    logic [12:0] prim_key;
    logic [7:0]  sec_pix [8];
    logic [7:0]  sec_mask;
    logic [12:0] sec_key;
    logic [2:0]  idx;
    logic        rb_mode;
    logic [2:0]  rb_px;
    logic [7:0]  rb_val;
    ppcw_pkg::ppcw_wst_t  wst;
    ppcw_pkg::ppcw_rbst_t rb_st;

    // ----------------------------------------
    // Decode and plot evaluation
    // ----------------------------------------
    logic [3:0]  reg_idx;
    logic        commit;
    logic        cmd_go;
    logic [2:0]  op;
    logic        bpp2;
    logic        bpp8;
    logic [1:0]  ht;
    logic [2:0]  last_idx;
    logic [12:0] key_c;
    logic [7:0]  bitm;
    logic [7:0]  pcol;
    logic        opaque;
    logic        hit;
    logic        full;
    logic [7:0]  upd_mask;
    logic        plot_go;
    logic        plot_xfer;
    logic        rb_xfer;
    logic        rb_launch;
    logic        do_xfer;
    logic [7:0]  xfer_mask;
    logic        can_ack;
    logic [31:0] rd_mux;
    logic [31:0] area;
    logic [7:0]  load_val;

    assign reg_idx  = avs_address[5:2];
    assign commit   = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign cmd_go   = commit && reg_idx == ppcw_pkg::REG_CMD;
    assign op       = avs_writedata[2:0];
    assign bpp2     = layout[1:0] == ppcw_pkg::CM_2BPP;
    assign bpp8     = layout[1:0] == ppcw_pkg::CM_8BPP;
    assign ht       = por[ppcw_pkg::POR_OBJ] ? ppcw_pkg::HT_OBJ : layout[3:2];
    assign last_idx = bpp2 ? 3'h1 : (bpp8 ? 3'h7 : 3'h3);
    assign key_c    = {x[7:3], y};
    assign bitm     = 8'h01 << x[2:0];

    always_comb
    begin
        pcol = color;
        if (por[ppcw_pkg::POR_DITHER] && !bpp8)
        begin
            pcol = {4'h0, (x[0] ^ y[0]) ? color[7:4] : color[3:0]};
        end
        if (por[ppcw_pkg::POR_TRANSP])
            opaque = 1'b1;
        else if (bpp2)
            opaque = pcol[1:0] != 2'h0;
        else if (!bpp8 || por[ppcw_pkg::POR_FREEZE])
            opaque = pcol[3:0] != 4'h0;
        else
            opaque = pcol != 8'h00;
    end

    assign hit       = prim_mask == 8'h00 || key_c == prim_key;
    assign upd_mask  = prim_mask | bitm;
    assign full      = hit && upd_mask == ppcw_pkg::ROW_FULL;
    assign plot_go   = cmd_go && op == ppcw_pkg::OP_PLOT && opaque;
    assign plot_xfer = plot_go && (!hit || full);
    assign rb_xfer   = rb_st == ppcw_pkg::R_FLUSH && prim_mask != 8'h00 && wst == ppcw_pkg::W_IDLE;
    assign rb_launch = rb_st == ppcw_pkg::R_FLUSH && prim_mask == 8'h00 && wst == ppcw_pkg::W_IDLE;
    assign do_xfer   = plot_xfer || rb_xfer;
    assign xfer_mask = (plot_go && full) ? ppcw_pkg::ROW_FULL : prim_mask;

    // A plot that must hand over a row waits while the secondary is busy
    always_comb
    begin
        can_ack = 1'b1;
        if (avs_write && reg_idx == ppcw_pkg::REG_CMD)
        begin
            if (rb_st != ppcw_pkg::R_IDLE)
                can_ack = 1'b0;
            else if (op == ppcw_pkg::OP_PLOT && opaque && (!hit || full) && wst != ppcw_pkg::W_IDLE)
                can_ack = 1'b0;
        end
    end

    // Bytes = height/8 * width/8 * 8 * bits per pixel
    always_comb
    begin
        logic [9:0] hch;
        logic [9:0] wch;
        hch = ppcw_pkg::CHARS_OBJ;
        wch = ppcw_pkg::CHARS_OBJ;
        if (ht == ppcw_pkg::HT_128)
            hch = ppcw_pkg::CHARS_128;
        else if (ht == ppcw_pkg::HT_160)
            hch = ppcw_pkg::CHARS_160;
        else if (ht == ppcw_pkg::HT_192)
            hch = ppcw_pkg::CHARS_192;
        if (ht != ppcw_pkg::HT_OBJ)
            wch = 10'(SCREEN_WIDTH / 8);
        area = (32'(hch) * 32'(wch)) << (bpp2 ? 4 : (bpp8 ? 6 : 5));
    end

    always_comb
    begin
        case (reg_idx)
            ppcw_pkg::REG_COLOR:  rd_mux = {24'h0, color};
            ppcw_pkg::REG_X:      rd_mux = {24'h0, x};
            ppcw_pkg::REG_Y:      rd_mux = {24'h0, y};
            ppcw_pkg::REG_SRC:    rd_mux = {24'h0, src};
            ppcw_pkg::REG_POR:    rd_mux = {27'h0, por};
            ppcw_pkg::REG_BASE:   rd_mux = {24'h0, base};
            ppcw_pkg::REG_LAYOUT: rd_mux = {28'h0, layout};
            ppcw_pkg::REG_STATUS: rd_mux = {8'h0, prim_mask, 6'h0, rb_st != ppcw_pkg::R_IDLE,
                                            wst != ppcw_pkg::W_IDLE, rb_val};
            ppcw_pkg::REG_AREA:   rd_mux = area;
            default:              rd_mux = 32'h0;
        endcase
    end

    // ----------------------------------------
    // Bus slave: one wait cycle at least, longer while stalled
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end
        else if (!avs_waitrequest)
            avs_waitrequest <= 1'b1;
        else if ((avs_read || avs_write) && can_ack)
        begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_mux : 32'h0;
        end
    end

    // ----------------------------------------
    // Software-written registers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            src    <= 8'h00;
            base   <= 8'h00;
            layout <= 4'h0;
        end
        else if (commit)
        begin
            if (reg_idx == ppcw_pkg::REG_SRC)
                src <= avs_writedata[7:0];
            if (reg_idx == ppcw_pkg::REG_BASE)
                base <= avs_writedata[7:0];
            if (reg_idx == ppcw_pkg::REG_LAYOUT)
                layout <= avs_writedata[3:0];
        end
    end

    // Source of a color load, high nibble moved down when asked for
    always_comb
    begin
        load_val = por[ppcw_pkg::POR_HINIB] ? {4'h0, src[7:4]} : src;
        if (op == ppcw_pkg::OP_ROMC)
            load_val = por[ppcw_pkg::POR_HINIB] ? {4'h0, rom_byte[7:4]} : rom_byte;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            color <= 8'h00;
            por   <= 5'h00;
        end
        else if (cmd_go && (op == ppcw_pkg::OP_COLOR || op == ppcw_pkg::OP_ROMC))
            color <= por[ppcw_pkg::POR_FREEZE] ? {color[7:4], load_val[3:0]} : load_val;
        else if (cmd_go && op == ppcw_pkg::OP_MODE)
            por <= src[4:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            x <= 8'h00;
            y <= 8'h00;
        end
        else if (cmd_go && op == ppcw_pkg::OP_PLOT)
            x <= x + 8'h01;
        else if (commit && reg_idx == ppcw_pkg::REG_X)
            x <= avs_writedata[7:0];
        else if (commit && reg_idx == ppcw_pkg::REG_Y)
            y <= avs_writedata[7:0];
    end

    // ----------------------------------------
    // Primary cache
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            prim_mask <= 8'h00;
            prim_key  <= 13'h0;
        end
        else if (plot_go)
        begin
            prim_key          <= key_c;
            prim_pix[x[2:0]]  <= pcol;
            prim_mask         <= full ? 8'h00 : (hit ? upd_mask : bitm);
        end
        else if (rb_xfer)
            prim_mask <= 8'h00;
    end

    // ----------------------------------------
    // Secondary cache and RAM sequencer
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wst      <= ppcw_pkg::W_IDLE;
            sec_mask <= 8'h00;
            sec_key  <= 13'h0;
            idx      <= 3'h0;
            rb_mode  <= 1'b0;
            rb_px    <= 3'h0;
            rb_val   <= 8'h00;
        end
        else if (do_xfer)
        begin
            for (int k = 0; k < 8; k++)
                sec_pix[k] <= prim_pix[k];
            if (plot_go && full)
                sec_pix[x[2:0]] <= pcol;
            sec_mask <= xfer_mask;
            sec_key  <= prim_key;
            rb_mode  <= 1'b0;
            idx      <= 3'h0;
            wst      <= (xfer_mask == ppcw_pkg::ROW_FULL) ? ppcw_pkg::W_WRITE : ppcw_pkg::W_READ;
        end
        else if (rb_launch)
        begin
            sec_key <= key_c;
            rb_px   <= x[2:0];
            rb_mode <= 1'b1;
            rb_val  <= 8'h00;
            idx     <= 3'h0;
            wst     <= ppcw_pkg::W_READ;
        end
        else if (ram_req && ram_ack)
        begin
            case (wst)
                ppcw_pkg::W_READ:
                begin
                    if (rb_mode)
                        rb_val[idx] <= ram_rdata[~rb_px];
                    else
                        for (int k = 0; k < 8; k++)
                            if (!sec_mask[k])
                                sec_pix[k][idx] <= ram_rdata[7 - k];
                    idx <= (idx == last_idx) ? 3'h0 : idx + 3'h1;
                    if (idx == last_idx)
                        wst <= rb_mode ? ppcw_pkg::W_IDLE : ppcw_pkg::W_WRITE;
                end
                ppcw_pkg::W_WRITE:
                begin
                    idx <= (idx == last_idx) ? 3'h0 : idx + 3'h1;
                    if (idx == last_idx)
                        wst <= ppcw_pkg::W_IDLE;
                end
                default:
                    wst <= ppcw_pkg::W_IDLE;
            endcase
        end
    end

    // Mode must stay fixed while a row is in flight, since the address uses it
    logic [4:0]  sx;
    logic [7:0]  sy;
    logic [9:0]  cn;
    logic [9:0]  hmul;
    logic [23:0] addr_c;
    logic [7:0]  wdata_c;

    assign sx = sec_key[12:8];
    assign sy = sec_key[7:0];
    assign hmul = (ht == ppcw_pkg::HT_160) ? ppcw_pkg::CHARS_160 :
                  (ht == ppcw_pkg::HT_192) ? ppcw_pkg::CHARS_192 : ppcw_pkg::CHARS_128;
    assign cn = (ht == ppcw_pkg::HT_OBJ) ? {sy[7], sx[4], sy[6:3], sx[3:0]}
                                         : 10'(sx * hmul) + 10'(sy[7:3]);
    assign addr_c = ppcw_pkg::RAM_BANK_BASE + {6'h0, base, 10'h0}
                  + (24'(cn) << (bpp2 ? 4 : (bpp8 ? 6 : 5)))
                  + {20'h0, sy[2:0], 1'b0} + {18'h0, idx[2:1], 4'h0} + {23'h0, idx[0]};

    for (genvar j = 0; j < 8; j++)
    begin : g_plane
        assign wdata_c[j] = sec_pix[7 - j][idx];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ram_req   <= 1'b0;
            ram_we    <= 1'b0;
            ram_addr  <= 24'h0;
            ram_wdata <= 8'h00;
        end
        else
        begin
            ram_req   <= wst != ppcw_pkg::W_IDLE && !(ram_req && ram_ack);
            ram_we    <= wst == ppcw_pkg::W_WRITE;
            ram_addr  <= addr_c;
            ram_wdata <= wdata_c;
        end
    end

    // ----------------------------------------
    // Read-back sequencer
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rb_st <= ppcw_pkg::R_IDLE;
        else
            case (rb_st)
                ppcw_pkg::R_IDLE:
                    if (cmd_go && op == ppcw_pkg::OP_PIXEL_READBACK_FLUSH)
                        rb_st <= ppcw_pkg::R_FLUSH;
                ppcw_pkg::R_FLUSH:
                    if (rb_launch)
                        rb_st <= ppcw_pkg::R_READ;
                ppcw_pkg::R_READ:
                    if (wst == ppcw_pkg::W_IDLE)
                        rb_st <= ppcw_pkg::R_IDLE;
                default:
                    rb_st <= ppcw_pkg::R_IDLE;
            endcase
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_read_starts;
        ##2 (ram_req && !ram_we);
    endsequence

    property p_base;
        ram_req |-> ram_addr >= ppcw_pkg::RAM_BANK_BASE + {6'h0, base, 10'h0};
    endproperty
    a_base: assert property (p_base) else $error("RAM address below area base");

    property p_color;
        cmd_go && op == ppcw_pkg::OP_COLOR && !por[ppcw_pkg::POR_HINIB] && !por[ppcw_pkg::POR_FREEZE]
        |=> color == $past(src);
    endproperty
    a_color: assert property (p_color) else $error("Color load lost source");

    property p_xinc;
        cmd_go && op == ppcw_pkg::OP_PLOT |=> x == $past(x) + 8'h01;
    endproperty
    a_xinc: assert property (p_xinc) else $error("Plot did not advance X");

    property p_transp;
        cmd_go && op == ppcw_pkg::OP_PLOT && !opaque |=> prim_mask == $past(prim_mask) && sec_mask == $past(sec_mask);
    endproperty
    a_transp: assert property (p_transp) else $error("Transparent plot touched cache");

    property p_full;
        plot_go && full |=> prim_mask == 8'h00 && sec_mask == ppcw_pkg::ROW_FULL
                            ##1 ram_req && ram_we;
    endproperty
    a_full: assert property (p_full) else $error("Full row not flushed");

    property p_stall;
        avs_waitrequest && avs_write && reg_idx == ppcw_pkg::REG_CMD && op == ppcw_pkg::OP_PLOT
        && opaque && !hit && wst != ppcw_pkg::W_IDLE |=> avs_waitrequest;
    endproperty
    a_stall: assert property (p_stall) else $error("Plot accepted while secondary busy");

    property p_merge;
        do_xfer && xfer_mask != ppcw_pkg::ROW_FULL |-> s_read_starts;
    endproperty
    a_merge: assert property (p_merge) else $error("Partial row not read first");

    property p_rb_read;
        rb_launch |-> s_read_starts;
    endproperty
    a_rb_read: assert property (p_rb_read) else $error("Read-back skipped RAM read");

    property p_no_empty_write;
        ram_req && ram_we |-> !rb_mode && sec_mask != 8'h00;
    endproperty
    a_no_empty_write: assert property (p_no_empty_write) else $error("Write of empty row");

    property p_row_change;
        plot_go && !hit |=> prim_mask == $past(bitm) && sec_key == $past(prim_key);
    endproperty
    a_row_change: assert property (p_row_change) else $error("Row change mishandled");
endmodule : ppcw_plot_writer

// ---- verification/ppcw_ram_model.sv ----
/*
 Cartridge work RAM model for the plot writer, byte wide, slow or quick.
 Assumes one access at a time, held until ram_ack.
*/
`timescale 1ns/1ps
module ppcw_ram_model (
    // Clock
    input  wire logic        clk_sys,
    // Access from the writer
    input  wire logic        ram_req,
    input  wire logic        ram_we,
    input  wire logic [23:0] ram_addr,
    input  wire logic [7:0]  ram_wdata,
    output logic             ram_ack,
    output logic      [7:0]  ram_rdata,
    // Wait cycles before each answer
    input  wire logic [3:0]  delay
);
    logic [7:0] mem [int];
    int         cnt  = 0;
    int         n_rd = 0;
    int         n_wr = 0;
    initial ram_ack   = 1'b0;
    initial ram_rdata = 8'h00;
    // Data lines flip outside an answer so a stale byte never looks valid
    always @(posedge clk_sys)
    begin
        ram_ack   <= 1'b0;
        ram_rdata <= ~ram_rdata;
        if (ram_req && ram_ack)
        begin
            if (ram_we)
            begin
                mem[ram_addr] = ram_wdata;
                n_wr++;
            end
            else
                n_rd++;
        end
        else if (ram_req && cnt >= delay)
        begin
            cnt     = 0;
            ram_ack <= 1'b1;
            if (!ram_we)
                ram_rdata <= mem.exists(ram_addr) ? mem[ram_addr] : 8'h00;
        end
        else if (ram_req)
            cnt++;
    end
endmodule : ppcw_ram_model

// ---- verification/plot_pixel_cache_writer_test.sv ----
/*
 Self-checking bench for the plot writer: Avalon-MM driver, RAM model.
 Assumes 8 bits per pixel, 128-line layout, default width.
*/
`timescale 1ns/1ps
module plot_pixel_cache_writer_test;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  rom_byte = 8'h00;
    logic        ram_req, ram_we, ram_ack;
    logic [23:0] ram_addr;
    logic [7:0]  ram_wdata, ram_rdata, x, y, c, base;
    logic [3:0]  delay = 4'h0;
    logic [7:0]  px [16];
    logic [31:0] q;
    int          bad_count = 0;
    int          num_checks = 0;
    int          nr, nw;
    ppcw_plot_writer uut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rom_byte(rom_byte),
        .ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .ram_ack(ram_ack), .ram_rdata(ram_rdata));
    ppcw_ram_model ram (.clk_sys(clk_sys), .ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr),
        .ram_wdata(ram_wdata), .ram_ack(ram_ack), .ram_rdata(ram_rdata), .delay(delay));
    initial forever #10 clk_sys = ~clk_sys;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address   <= {idx, 2'h0};
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= d;
        do
        begin
            @(posedge clk_sys);
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus
    task automatic plot_px(input logic [7:0] col, input logic rom);
        rom_byte <= col;
        if (!rom)
            bus(1'b1, ppcw_pkg::REG_SRC, col);
        bus(1'b1, ppcw_pkg::REG_CMD, rom ? ppcw_pkg::OP_ROMC : ppcw_pkg::OP_COLOR);
        bus(1'b1, ppcw_pkg::REG_CMD, ppcw_pkg::OP_PLOT);
    endtask : plot_px
    task automatic wait_idle;
        do
        begin
            bus(1'b0, ppcw_pkg::REG_STATUS, 32'h0);
        end
        while (q[9:8] !== 2'h0);
    endtask : wait_idle
    // Planar byte address of plane i for the row holding (xx, yy)
    function automatic logic [23:0] adr(input logic [7:0] xx, input logic [7:0] yy, input int i);
        logic [23:0] cn;
        cn = xx[7:3] * 16 + yy[7:3];
        return ppcw_pkg::RAM_BANK_BASE + base * 24'h400 + cn * 64 + yy[2:0] * 2 + (i >> 1) * 16 + (i & 1);
    endfunction : adr
    // Leftmost pixel lands in bit 7 of every plane
    function automatic logic [7:0] plane(input int i, input int o);
        for (int k = 0; k < 8; k++)
            plane[7 - k] = px[o + k][i];
    endfunction : plane
    task automatic chk_row(input logic [7:0] xx, input logic [7:0] yy, input int o);
        for (int i = 0; i < 8; i++)
            chk("ram", plane(i, o), ram.mem[adr(xx, yy, i)]);
    endtask : chk_row
    task automatic report_and_stop;
        $display("checks %0d bad %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        bad_count++;
        report_and_stop();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        void'($urandom(14654));
        base = $urandom % 256;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        chk("wait", 1, avs_waitrequest);
        bus(1'b1, ppcw_pkg::REG_BASE, base);
        bus(1'b1, ppcw_pkg::REG_LAYOUT, {ppcw_pkg::HT_128, ppcw_pkg::CM_8BPP});
        bus(1'b0, ppcw_pkg::REG_AREA, 32'h0);
        chk("area", 32'h8000, q);
        bus(1'b0, 4'ha, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("setup done");
        // Two full rows back to back; slow RAM makes the second handover wait
        delay <= 4'h7;
        x = ($urandom % 30) * 8;
        y = $urandom % 128;
        bus(1'b1, ppcw_pkg::REG_X, x);
        bus(1'b1, ppcw_pkg::REG_Y, y);
        for (int k = 0; k < 16; k++)
        begin
            // Zero would be transparent and leave the row unfinished
            px[k] = 8'($urandom % 255) + 8'h01;
            plot_px(px[k], k[0]);
        end
        bus(1'b0, ppcw_pkg::REG_COLOR, 32'h0);
        chk("color", px[15], q[7:0]);
        wait_idle();
        chk_row(x, y, 0);
        chk_row(x + 8, y, 8);
        bus(1'b0, ppcw_pkg::REG_X, 32'h0);
        chk("x", x + 16, q[7:0]);
        $display("full rows done");
        // Partial row merged with RAM; a zero color leaves the old pixel
        delay <= $urandom % 3;
        y = (y + 8) % 128;
        for (int i = 0; i < 8; i++)
            ram.mem[adr(x, y, i)] = $urandom;
        for (int k = 0; k < 8; k++)
            for (int i = 0; i < 8; i++)
                px[k][i] = ram.mem[adr(x, y, i)][7 - k];
        px[0] = $urandom | 8'h01;
        px[2] = $urandom | 8'h01;
        c = $urandom | 8'h01;
        bus(1'b1, ppcw_pkg::REG_X, x);
        bus(1'b1, ppcw_pkg::REG_Y, y);
        plot_px(px[0], 1'b0);
        plot_px(8'h00, 1'b0);
        plot_px(px[2], 1'b1);
        bus(1'b1, ppcw_pkg::REG_X, x + 8);
        plot_px(c, 1'b0);
        wait_idle();
        chk_row(x, y, 0);
        $display("merge done");
        // Read-back flushes the lone pixel, then always rereads RAM
        bus(1'b1, ppcw_pkg::REG_X, x + 8);
        bus(1'b1, ppcw_pkg::REG_CMD, ppcw_pkg::OP_PIXEL_READBACK_FLUSH);
        wait_idle();
        chk("pix", c, q[7:0]);
        nr = ram.n_rd;
        nw = ram.n_wr;
        bus(1'b1, ppcw_pkg::REG_CMD, ppcw_pkg::OP_PIXEL_READBACK_FLUSH);
        wait_idle();
        chk("pix2", c, q[7:0]);
        chk("reads", nr + 8, ram.n_rd);
        chk("writes", nw, ram.n_wr);
        $display("read-back done");
        // Mode-set loads the option register; direct writes are refused
        bus(1'b1, ppcw_pkg::REG_SRC, 32'h13);
        bus(1'b1, ppcw_pkg::REG_CMD, ppcw_pkg::OP_MODE);
        bus(1'b1, ppcw_pkg::REG_POR, 32'h0);
        bus(1'b0, ppcw_pkg::REG_POR, 32'h0);
        chk("por", 8'h13, q[7:0]);
        $display("mode done");
        report_and_stop();
    end
endmodule : plot_pixel_cache_writer_test
